//--- rtl/rcd_pkg.sv
// Package for the calendar clock divider and write lock.
// Assumes a 16-bit register port with byte addresses and one system clock.
package rcd_pkg;

  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] OFS_CTRL1L = 8'h00;
  localparam logic [7:0] OFS_CTRL2L = 8'h04;
  localparam logic [7:0] OFS_CTRL2H = 8'h08;
  localparam logic [7:0] OFS_KEY = 8'h0C;
  localparam logic [7:0] OFS_TIME = 8'h10;
  localparam logic [7:0] OFS_DATE = 8'h14;
  localparam logic [7:0] OFS_ALM_TIME = 8'h18;
  localparam logic [7:0] OFS_ALM_DATE = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_PWC = 8'h24;

  // ********************************
  // Field positions
  // ********************************
  localparam int BIT_EN = 15;
  localparam int BIT_LOCK = 11;
  localparam int FD_HI = 15;
  localparam int FD_LO = 11;
  localparam int PS_HI = 5;
  localparam int PS_LO = 4;
  localparam int CS_HI = 1;
  localparam int CS_LO = 0;

  // ********************************
  // Codes and reset values
  // ********************************
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [1:0] SRC_SEC_OSC = 2'h0;
  localparam logic [1:0] SRC_RC = 2'h1;
  localparam logic [1:0] SRC_LINE = 2'h2;
  localparam logic [1:0] SRC_SYS = 2'h3;
  localparam logic [15:0] RST_DIV = 16'h0000;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Last prescaler count for each ratio
  localparam logic [7:0] PS_LAST_1 = 8'h00;
  localparam logic [7:0] PS_LAST_16 = 8'h0F;
  localparam logic [7:0] PS_LAST_64 = 8'h3F;
  localparam logic [7:0] PS_LAST_256 = 8'hFF;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'h1,
    KEY_HALF = 3'h2,
    KEY_OPEN = 3'h4
  } rcd_key_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rcd_bus_t;

  typedef struct packed {
    logic en;
    logic lock;
    logic [1:0] clksel;
    logic [1:0] ps;
    logic [4:0] fdiv;
    logic [15:0] div;
    logic [15:0] time_v;
    logic [15:0] date_v;
    logic [15:0] alm_time;
    logic [15:0] alm_date;
    logic [15:0] pwc;
    rcd_key_t key;
    logic src_prev;
    logic [7:0] pre_cnt;
    logic [15:0] div_cnt;
    logic [4:0] hs_idx;
    logic skip;
    logic half_phase;
    logic half_tick;
    logic sec_tick;
    logic [15:0] rdata;
  } rcd_state_t;

  function automatic logic [7:0] rcd_ps_last(input logic [1:0] ps);
    case (ps)
      2'h1: rcd_ps_last = PS_LAST_16;
      2'h2: rcd_ps_last = PS_LAST_64;
      2'h3: rcd_ps_last = PS_LAST_256;
      default: rcd_ps_last = PS_LAST_1;
    endcase
  endfunction

endpackage

//--- rtl/rcd_clock_divider.sv
// Clock source select, prescaler, coarse and fine divider, and write lock.
// Assumes source levels synchronous to CLK and a single-master register port.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// Contract
// - Source select 00 secondary osc, 01 RC osc, 10 powerline, 11 system clock.
// - Prescaler passes selected source through or divides it by 16, 64 or 256.
// - Sixteen-bit counter divides prescaled clock by coarse value plus one.
// - Divider delivers half-second and one-second ticks.
// - Fine value zero means coarse division only.
// - Nonzero fine value removes that many pulses per 32 half-seconds.
// - Larger fine value lengthens the divider period.
// - Each fine unit adds one thirty-second count to the divisor.
// - Every reset clears the write lock.
// - Lock discards writes to enable, control two and time/date.
// - Alarm and power control writes ignore the lock.
// - Lock clears only right after key writes 55 then AA.
// - Unlocked lock bit is set by a plain write.
// - Time, date and alarm registers are directly addressable.
module rcd_clock_divider (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic SEC_OSC,
  input wire logic RC_OSC,
  input wire logic LINE_CLK,
  output logic HALF_TICK,
  output logic SECOND_TICK,
  output logic UNIT_EN,
  output logic LOCKED
);

  rcd_pkg::rcd_state_t s;
  rcd_pkg::rcd_state_t next_s;
  rcd_pkg::rcd_bus_t bus;
  logic src_lvl;
  logic src_edge;
  logic pre_pulse;
  logic half_evt;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // ********************************
  // Source selection
  // ********************************
  always_comb begin
    case (s.clksel)
      rcd_pkg::SRC_SEC_OSC: src_lvl = SEC_OSC;
      rcd_pkg::SRC_RC: src_lvl = RC_OSC;
      rcd_pkg::SRC_LINE: src_lvl = LINE_CLK;
      default: src_lvl = 1'b1;
    endcase
    src_edge = (s.clksel == rcd_pkg::SRC_SYS) ? 1'b1 : (src_lvl & ~s.src_prev);
  end

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    next_s = s;
    next_s.half_tick = 1'b0;
    next_s.sec_tick = 1'b0;
    next_s.rdata = rcd_pkg::RST_WORD;
    next_s.src_prev = src_lvl;
    pre_pulse = 1'b0;
    half_evt = 1'b0;
    if (s.key == rcd_pkg::KEY_OPEN) begin
      next_s.key = rcd_pkg::KEY_IDLE;
    end

    // Key sequence tracking
    if (bus.wr) begin
      if (bus.addr == rcd_pkg::OFS_KEY) begin
        if (bus.wdata[7:0] == rcd_pkg::KEY_FIRST) begin
          next_s.key = rcd_pkg::KEY_HALF;
        end else if (s.key == rcd_pkg::KEY_HALF && bus.wdata[7:0] == rcd_pkg::KEY_SECOND) begin
          next_s.key = rcd_pkg::KEY_OPEN;
        end else begin
          next_s.key = rcd_pkg::KEY_IDLE;
        end
      end else begin
        next_s.key = rcd_pkg::KEY_IDLE;
      end
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        rcd_pkg::OFS_CTRL1L: begin
          if (!s.lock) begin
            next_s.en = bus.wdata[rcd_pkg::BIT_EN];
            next_s.lock = bus.wdata[rcd_pkg::BIT_LOCK];
          end else if (s.key == rcd_pkg::KEY_OPEN && !bus.wdata[rcd_pkg::BIT_LOCK]) begin
            next_s.lock = 1'b0;
          end
        end
        rcd_pkg::OFS_CTRL2L: begin
          if (!s.lock) begin
            next_s.fdiv = bus.wdata[rcd_pkg::FD_HI:rcd_pkg::FD_LO];
            next_s.ps = bus.wdata[rcd_pkg::PS_HI:rcd_pkg::PS_LO];
            next_s.clksel = bus.wdata[rcd_pkg::CS_HI:rcd_pkg::CS_LO];
          end
        end
        rcd_pkg::OFS_CTRL2H: begin
          if (!s.lock) begin
            next_s.div = bus.wdata;
          end
        end
        rcd_pkg::OFS_TIME: begin
          if (!s.lock) begin
            next_s.time_v = bus.wdata;
          end
        end
        rcd_pkg::OFS_DATE: begin
          if (!s.lock) begin
            next_s.date_v = bus.wdata;
          end
        end
        rcd_pkg::OFS_ALM_TIME: next_s.alm_time = bus.wdata;
        rcd_pkg::OFS_ALM_DATE: next_s.alm_date = bus.wdata;
        rcd_pkg::OFS_PWC: next_s.pwc = bus.wdata;
        default: next_s.pwc = s.pwc;
      endcase
    end

    // Register reads
    if (bus.rd) begin
      case (bus.addr)
        rcd_pkg::OFS_CTRL1L: begin
          next_s.rdata[rcd_pkg::BIT_EN] = s.en;
          next_s.rdata[rcd_pkg::BIT_LOCK] = s.lock;
        end
        rcd_pkg::OFS_CTRL2L: begin
          next_s.rdata[rcd_pkg::FD_HI:rcd_pkg::FD_LO] = s.fdiv;
          next_s.rdata[rcd_pkg::PS_HI:rcd_pkg::PS_LO] = s.ps;
          next_s.rdata[rcd_pkg::CS_HI:rcd_pkg::CS_LO] = s.clksel;
        end
        rcd_pkg::OFS_CTRL2H: next_s.rdata = s.div;
        rcd_pkg::OFS_TIME: next_s.rdata = s.time_v;
        rcd_pkg::OFS_DATE: next_s.rdata = s.date_v;
        rcd_pkg::OFS_ALM_TIME: next_s.rdata = s.alm_time;
        rcd_pkg::OFS_ALM_DATE: next_s.rdata = s.alm_date;
        rcd_pkg::OFS_PWC: next_s.rdata = s.pwc;
        rcd_pkg::OFS_STATUS: next_s.rdata = {9'h000, s.half_phase, s.skip, s.hs_idx};
        default: next_s.rdata = rcd_pkg::RST_WORD;
      endcase
    end

    // ********************************
    // Divider chain
    // ********************************
    if (s.en) begin
      if (src_edge) begin
        if (s.pre_cnt == rcd_pkg::rcd_ps_last(s.ps)) begin
          next_s.pre_cnt = 8'h00;
          pre_pulse = 1'b1;
        end else begin
          next_s.pre_cnt = 8'(s.pre_cnt + 8'h01);
        end
      end
      if (pre_pulse) begin
        if (s.skip) begin
          next_s.skip = 1'b0;
        end else if (s.div_cnt == s.div) begin
          half_evt = 1'b1;
          next_s.div_cnt = rcd_pkg::RST_DIV;
        end else begin
          next_s.div_cnt = 16'(s.div_cnt + 16'h0001);
        end
      end
      if (half_evt) begin
        next_s.half_tick = 1'b1;
        next_s.sec_tick = s.half_phase;
        next_s.half_phase = ~s.half_phase;
        next_s.hs_idx = 5'(s.hs_idx + 5'h01);
        next_s.skip = (s.hs_idx < s.fdiv);
      end
    end else begin
      next_s.pre_cnt = 8'h00;
      next_s.div_cnt = rcd_pkg::RST_DIV;
      next_s.hs_idx = 5'h00;
      next_s.skip = 1'b0;
      next_s.half_phase = 1'b0;
    end
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= '{en: 1'b0, lock: 1'b0, clksel: rcd_pkg::SRC_SEC_OSC, ps: 2'h0, fdiv: 5'h00,
             div: rcd_pkg::RST_DIV, time_v: rcd_pkg::RST_WORD, date_v: rcd_pkg::RST_WORD,
             alm_time: rcd_pkg::RST_WORD, alm_date: rcd_pkg::RST_WORD,
             pwc: rcd_pkg::RST_WORD, key: rcd_pkg::KEY_IDLE, src_prev: 1'b0,
             pre_cnt: 8'h00, div_cnt: rcd_pkg::RST_DIV, hs_idx: 5'h00, skip: 1'b0,
             half_phase: 1'b0, half_tick: 1'b0, sec_tick: 1'b0,
             rdata: rcd_pkg::RST_WORD};
    end else begin
      s <= next_s;
    end
  end

  assign RDATA = s.rdata;
  assign HALF_TICK = s.half_tick;
  assign SECOND_TICK = s.sec_tick;
  assign UNIT_EN = s.en;
  assign LOCKED = s.lock;

  // ********************************
  // Assertions
  // ********************************
  sequence s_key55;
    WR && ADDR == rcd_pkg::OFS_KEY && WDATA[7:0] == rcd_pkg::KEY_FIRST;
  endsequence

  sequence s_keyaa;
    WR && ADDR == rcd_pkg::OFS_KEY && WDATA[7:0] == rcd_pkg::KEY_SECOND;
  endsequence

  sequence s_clear;
    WR && ADDR == rcd_pkg::OFS_CTRL1L && !WDATA[rcd_pkg::BIT_LOCK];
  endsequence

  property p_src_sys;
    @(posedge CLK) disable iff (RST) s.clksel == rcd_pkg::SRC_SYS |-> src_edge;
  endproperty
  a_src_sys: assert property (p_src_sys) else $error("system clock source lost edges");

  property p_ps_pass;
    @(posedge CLK) disable iff (RST) s.en && s.ps == 2'h0 && src_edge |-> pre_pulse;
  endproperty
  a_ps_pass: assert property (p_ps_pass) else $error("undivided prescaler missed pulse");

  property p_ps_count;
    @(posedge CLK) disable iff (RST)
      s.en && s.ps == 2'h1 && src_edge && s.pre_cnt != rcd_pkg::PS_LAST_16 |-> !pre_pulse;
  endproperty
  a_ps_count: assert property (p_ps_count) else $error("prescaler by 16 pulsed early");

  property p_coarse;
    @(posedge CLK) disable iff (RST)
      pre_pulse && !s.skip && s.div_cnt == s.div |=> HALF_TICK && s.div_cnt == rcd_pkg::RST_DIV;
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse terminal count gave no tick");

  property p_sec;
    @(posedge CLK) disable iff (RST) SECOND_TICK |-> HALF_TICK && !s.half_phase;
  endproperty
  a_sec: assert property (p_sec) else $error("second tick without half tick");

  property p_fine_off;
    @(posedge CLK) disable iff (RST) half_evt && s.fdiv == 5'h00 |=> !s.skip;
  endproperty
  a_fine_off: assert property (p_fine_off) else $error("pulse removal with fine value zero");

  property p_fine_on;
    @(posedge CLK) disable iff (RST) half_evt && s.hs_idx < s.fdiv |=> s.skip;
  endproperty
  a_fine_on: assert property (p_fine_on) else $error("pulse removal not armed");

  property p_lock_reset;
    @(posedge CLK) $fell(RST) |-> !LOCKED;
  endproperty
  a_lock_reset: assert property (p_lock_reset) else $error("lock set after reset");

  property p_locked_time;
    @(posedge CLK) disable iff (RST)
      LOCKED && WR && (ADDR == rcd_pkg::OFS_TIME || ADDR == rcd_pkg::OFS_CTRL2H)
      |=> $stable(s.time_v) && $stable(s.div);
  endproperty
  a_locked_time: assert property (p_locked_time) else $error("locked register changed");

  property p_alarm;
    @(posedge CLK) disable iff (RST)
      WR && ADDR == rcd_pkg::OFS_ALM_TIME |=> s.alm_time == $past(WDATA);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm write lost");

  property p_unlock;
    @(posedge CLK) disable iff (RST) s_key55 ##1 s_keyaa ##1 s_clear |=> !LOCKED;
  endproperty
  a_unlock: assert property (p_unlock) else $error("key sequence did not unlock");

  property p_no_clear;
    @(posedge CLK) disable iff (RST) LOCKED && s.key != rcd_pkg::KEY_OPEN |=> LOCKED;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("lock cleared without key");

  property p_set;
    @(posedge CLK) disable iff (RST)
      !LOCKED && WR && ADDR == rcd_pkg::OFS_CTRL1L && WDATA[rcd_pkg::BIT_LOCK] |=> LOCKED;
  endproperty
  a_set: assert property (p_set) else $error("plain lock set refused");

endmodule

//--- tb/rcd_osc_model.sv
// Free-running source oscillators for the calendar clock divider.
// Assumes levels may change just after each rising CLK edge.
`timescale 1ns/1ps
module rcd_osc_model #(
  parameter int H0 = 1,
  parameter int H1 = 2,
  parameter int H2 = 3
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SLOW,
  output logic SEC_OSC,
  output logic RC_OSC,
  output logic LINE_CLK
);
  localparam int HP [3] = '{H0, H1, H2};
  int cnt [3];
  logic [2:0] lvl;

  // ********
  // Square waves
  // ********
  // Toggle every HP cycles, one more when slow
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lvl <= 3'h0;
      for (int i = 0; i < 3; i++) cnt[i] <= 0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (cnt[i] >= HP[i] - 1 + int'(SLOW)) begin
          cnt[i] <= 0;
          lvl[i] <= ~lvl[i];
        end else begin
          cnt[i] <= cnt[i] + 1;
        end
      end
    end
  end

  assign SEC_OSC = lvl[0];
  assign RC_OSC = lvl[1];
  assign LINE_CLK = lvl[2];
endmodule

//--- tb/tb_rtc_clock_divider_write_lock.sv
// Self-checking bench for the calendar clock divider and write lock.
// Assumes the oscillator model beside the design and a 20 MHz clock.
`timescale 1ns/1ps
module tb_rtc_clock_divider_write_lock;
  localparam int SH [3] = '{1, 2, 3};
  localparam logic [15:0] EN = 16'h8000;
  localparam logic [15:0] LK = 16'h0800;
  localparam logic [7:0] RA [4] = '{rcd_pkg::OFS_TIME, rcd_pkg::OFS_DATE,
    rcd_pkg::OFS_ALM_TIME, rcd_pkg::OFS_ALM_DATE};
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic SLOW = 1'b0;
  logic [15:0] RDATA;
  logic SEC_OSC, RC_OSC, LINE_CLK, HALF_TICK, SECOND_TICK, UNIT_EN, LOCKED;
  int n_fail = 0;
  int checks = 0;

  rcd_clock_divider dut_u (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SEC_OSC(SEC_OSC), .RC_OSC(RC_OSC), .LINE_CLK(LINE_CLK),
    .HALF_TICK(HALF_TICK), .SECOND_TICK(SECOND_TICK), .UNIT_EN(UNIT_EN), .LOCKED(LOCKED));
  rcd_osc_model #(.H0(SH[0]), .H1(SH[1]), .H2(SH[2])) osc_u (.CLK(CLK), .RST(RST),
    .SLOW(SLOW), .SEC_OSC(SEC_OSC), .RC_OSC(RC_OSC), .LINE_CLK(LINE_CLK));

  initial begin
    forever #25 CLK = ~CLK;
  end

  // ********
  // Tasks
  // ********
  task automatic complete_run();
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask

  task automatic cfg(input logic [1:0] s, input logic [1:0] p, input logic [15:0] dv,
                     input logic [4:0] f);
    wr(rcd_pkg::OFS_CTRL1L, 16'h0000);
    wr(rcd_pkg::OFS_CTRL2L, {f, 5'h00, p, 2'h0, s});
    wr(rcd_pkg::OFS_CTRL2H, dv);
    wr(rcd_pkg::OFS_CTRL1L, EN);
  endtask

  task automatic meas(input int n, output int cyc, output int secs);
    int k;
    k = 0;
    cyc = 0;
    secs = 0;
    while (HALF_TICK !== 1'b1 && k < 3000) begin
      @(posedge CLK);
      #1;
      k++;
    end
    k = 0;
    while (k < n && cyc < 20000) begin
      @(posedge CLK);
      #1;
      cyc++;
      if (HALF_TICK === 1'b1) begin
        k++;
        if (SECOND_TICK === 1'b1) secs++;
      end
    end
    if (k < n) begin
      chk(16'(k), 16'(n));
      complete_run();
    end
  endtask

  function automatic int ps_ratio(input int p);
    return (p == 0) ? 1 : (16 << (2 * (p - 1)));
  endfunction

  function automatic int src_per(input int s, input int sl);
    return (s == 3) ? 1 : 2 * (SH[s] + sl);
  endfunction

  function automatic int exp_span(input int per, input int p, input int dv, input int f,
                                  input int n);
    return per * ps_ratio(p) * (n * (dv + 1) + f);
  endfunction

  // ********
  // Main sequence
  // ********
  initial begin
    logic [15:0] v;
    logic [15:0] vals [4];
    int cyc, secs, dv, f, sl;
    void'($urandom(32'h2b88e7fc));
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    #1;
    chk(16'({UNIT_EN, LOCKED}), 16'h0000);
    rdc(rcd_pkg::OFS_CTRL1L, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      vals[i] = 16'($urandom());
      wr(RA[i], vals[i]);
    end
    for (int i = 0; i < 4; i++) rdc(RA[i], vals[i]);
    @(posedge CLK);
    #1;
    chk(RDATA, 16'h0000);
    rdc(8'h40, 16'h0000);
    for (int p = 0; p < 4; p++) begin
      dv = int'($urandom_range(3, 0));
      cfg(2'h3, 2'(p), 16'(dv), 5'h00);
      meas(2, cyc, secs);
      chk(16'(cyc), 16'(exp_span(1, p, dv, 0, 2)));
      chk(16'(secs), 16'h0001);
    end
    for (int s = 0; s < 4; s++) begin
      sl = int'($urandom_range(1, 0));
      SLOW <= 1'(sl);
      cfg(2'(s), 2'h0, 16'h0001, 5'h00);
      meas(4, cyc, secs);
      chk(16'(cyc), 16'(exp_span(src_per(s, sl), 0, 1, 0, 4)));
      chk(16'(secs), 16'h0002);
    end
    for (int j = 0; j < 3; j++) begin
      f = (j == 0) ? 31 : (j == 1) ? 1 : int'($urandom_range(30, 2));
      dv = int'($urandom_range(4, 1));
      cfg(2'h3, 2'h0, 16'(dv), 5'(f));
      meas(32, cyc, secs);
      chk(16'(cyc), 16'(exp_span(1, 0, dv, f, 32)));
    end
    cfg(2'h3, 2'h0, 16'h0003, 5'h00);
    v = 16'($urandom());
    wr(rcd_pkg::OFS_TIME, v);
    wr(rcd_pkg::OFS_CTRL1L, EN | LK);
    chk(16'(LOCKED), 16'h0001);
    wr(rcd_pkg::OFS_CTRL1L, LK);
    wr(rcd_pkg::OFS_CTRL2H, 16'hFFFC);
    wr(rcd_pkg::OFS_CTRL2L, 16'hFFFF);
    wr(rcd_pkg::OFS_TIME, ~v);
    wr(rcd_pkg::OFS_DATE, ~vals[1]);
    wr(rcd_pkg::OFS_ALM_TIME, ~v);
    wr(rcd_pkg::OFS_PWC, v);
    chk(16'(UNIT_EN), 16'h0001);
    rdc(rcd_pkg::OFS_CTRL2H, 16'h0003);
    rdc(rcd_pkg::OFS_CTRL2L, 16'h0003);
    rdc(rcd_pkg::OFS_TIME, v);
    rdc(rcd_pkg::OFS_DATE, vals[1]);
    rdc(rcd_pkg::OFS_ALM_TIME, ~v);
    rdc(rcd_pkg::OFS_PWC, v);
    wr(rcd_pkg::OFS_KEY, 16'h0055);
    wr(rcd_pkg::OFS_KEY, 16'h00AA);
    @(posedge CLK);
    #1;
    wr(rcd_pkg::OFS_CTRL1L, EN);
    chk(16'(LOCKED), 16'h0001);
    wr(rcd_pkg::OFS_KEY, 16'h0055);
    wr(rcd_pkg::OFS_ALM_DATE, 16'h1234);
    wr(rcd_pkg::OFS_KEY, 16'h00AA);
    wr(rcd_pkg::OFS_CTRL1L, EN);
    chk(16'(LOCKED), 16'h0001);
    wr(rcd_pkg::OFS_KEY, 16'h00AA);
    wr(rcd_pkg::OFS_KEY, 16'h0055);
    wr(rcd_pkg::OFS_CTRL1L, EN);
    chk(16'(LOCKED), 16'h0001);
    wr(rcd_pkg::OFS_KEY, 16'h0055);
    wr(rcd_pkg::OFS_KEY, 16'h00AA);
    wr(rcd_pkg::OFS_CTRL1L, EN);
    chk(16'({UNIT_EN, LOCKED}), 16'h0002);
    wr(rcd_pkg::OFS_CTRL1L, EN | LK);
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    #1;
    chk(16'({UNIT_EN, LOCKED}), 16'h0000);
    rdc(rcd_pkg::OFS_CTRL1L, 16'h0000);
    rdc(rcd_pkg::OFS_CTRL2H, rcd_pkg::RST_DIV);
    sl = 0;
    repeat (20) begin
      @(posedge CLK);
      #1;
      if (HALF_TICK !== 1'b0) sl++;
    end
    chk(16'(sl), 16'h0000);
    complete_run();
  end
endmodule
